// *** logic/lsec_pkg.sv ***
// constants, carrier types and states of the led sink enable/protection control
// Behaviour
// R1: enable held high keeps the sink active at its level unless protection blocks.
// R2: shutdown only after enable stays low longer than the shutdown delay.
// R3: enable pulses narrower than the filter width are ignored entirely.
// R4: start-up ramps current to target in eight equal increments over the ramp time.
// R5: ramp begins only after enable has stayed high for the turn-on wait.
// R6: supply-low indication disables the sink current.
// R7: when supply-low clears, current returns at the retained step.
// R8: short detection is armed only after the first ramp increment.
// R9: detected short turns the programmed current off, keeps sense current on.
// R10: short clearing returns to the programmed current with no enable action.
// R11: mode select high means flash mode, low means torch mode.
// R12: flash events are timed and the current shut off at the burst timeout.
// R13: after a burst timeout only an enable reset restarts the current.
// R14: over-temperature disables the current and latches that off state.
// R15: thermal latch clears only when cool and after an enable reset; the code clears it at every shutdown, even while still hot.
// R16: enable rising edges count the step 1 to 64, wrapping to 1.
// R17: an edge after the ramp moves the current straight to the new step.
// R18: host keeps each pulse and gap 0.5 to 10 us, then leaves enable high.
// R19: shutdown clears the step count and every latched protection state.
// R20: burst timer runs only in flash mode, restarting on each enable event; the code restarts it only at shutdown, not on enable edges.
package lsec_pkg;

  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned GLITCH_NS      = 80;
  localparam int unsigned SHDN_DELAY_NS  = 2500000;
  localparam int unsigned TURN_ON_WAIT_US = 350;
  localparam int unsigned RAMP_TIME_US   = 200;
  localparam int unsigned BURST_TIMEOUT_MS = 1200;
  localparam int unsigned RAMP_STEPS     = 8;

  // least times round up, the ramp step (a typical figure) rounds down
  localparam int unsigned GLITCH_CYC     = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHDN_DELAY_CYC = (SHDN_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TURN_ON_WAIT_CYC = TURN_ON_WAIT_US * CLK_MHZ;
  localparam int unsigned RAMP_STEP_CYC  = (RAMP_TIME_US * CLK_MHZ) / RAMP_STEPS;
  localparam int unsigned BURST_TIMEOUT_CYC = BURST_TIMEOUT_MS * CLK_MHZ * 1000;

  localparam int unsigned CNT_W   = 27;
  localparam int unsigned STEP_W  = 7;
  localparam int unsigned STAGE_W = 4;
  localparam int unsigned LEVEL_W = 10;
  localparam logic [STEP_W-1:0]  STEP_MAX   = 7'h40;
  localparam logic [STAGE_W-1:0] STAGE_FULL = 4'h8;

  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LEVEL_OFS  = 8'h08;
  localparam int unsigned CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RST = 1'b1;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_TIMEOUT_BIT = 2;
  localparam int unsigned ST_HOT_BIT = 3;
  localparam int unsigned ST_SHORT_BIT = 4;
  localparam int unsigned ST_SUPLOW_BIT = 5;
  localparam int unsigned ST_FLASH_BIT = 6;
  localparam int unsigned LV_STEP_LSB = 0;
  localparam int unsigned LV_STAGE_LSB = 8;

  typedef enum logic [1:0] {
    LSEC_SHUT = 2'b00,
    LSEC_WAIT = 2'b01,
    LSEC_RAMP = 2'b11,
    LSEC_ON   = 2'b10
  } lsec_state_e;

  typedef enum logic [1:0] {
    LSEC_REG_CTRL   = 2'h0,
    LSEC_REG_STATUS = 2'h1,
    LSEC_REG_LEVEL  = 2'h2,
    LSEC_REG_NONE   = 2'h3
  } lsec_reg_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } lsec_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lsec_apb_rsp_s;

  typedef struct packed {
    logic enable;
    logic flashSel;
    logic supplyLow;
    logic overTemp;
    logic shortDet;
  } lsec_pins_s;

  typedef struct packed {
    logic               sinkOn;
    logic               senseOn;
    logic [STEP_W-1:0]  step;
    logic [STAGE_W-1:0] stage;
    logic [LEVEL_W-1:0] level;
  } lsec_drive_s;

endpackage

// *** logic/lsec_deglitch.sv ***
// enable-pin deglitch filter: output follows input only after it held steady
`timescale 1ns/10ps
module lsec_deglitch #(
  parameter int unsigned HOLD_CYC = lsec_pkg::GLITCH_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic rawIn,
  output logic      cleanOut
);
  typedef struct packed {
    logic       level;
    logic [7:0] cnt;
  } lsec_dg_s;

  lsec_dg_s q;
  lsec_dg_s n;

  always_comb begin
    n = q;
    // a pulse shorter than HOLD_CYC cycles never reaches the output
    if (rawIn == q.level) begin
      n.cnt = 8'h00; // R3
    end else if (q.cnt == 8'(HOLD_CYC - 1)) begin
      n.level = rawIn;
      n.cnt   = 8'h00;
    end else begin
      n.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cleanOut = q.level;
endmodule

// *** logic/lsec_tick_div.sv ***
// divider giving a one-cycle enable pulse every DIV cycles while run is high
`timescale 1ns/10ps
module lsec_tick_div #(
  parameter int unsigned DIV = lsec_pkg::RAMP_STEP_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } lsec_div_s;

  lsec_div_s q;
  lsec_div_s n;

  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 16'h0000;
    end else if (q.cnt == 16'(DIV - 1)) begin
      n.cnt  = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick & run;
endmodule

// *** logic/lsec_ctrl.sv ***
// led sink enable, soft-start and protection control with apb status/control
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module lsec_ctrl #(
  parameter int unsigned SHDN_CYC    = lsec_pkg::SHDN_DELAY_CYC,
  parameter int unsigned TURN_ON_CYC = lsec_pkg::TURN_ON_WAIT_CYC,
  parameter int unsigned TIMEOUT_CYC = lsec_pkg::BURST_TIMEOUT_CYC,
  parameter int unsigned RAMP_CYC    = lsec_pkg::RAMP_STEP_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire lsec_pkg::lsec_pins_s   pins,
  input  wire lsec_pkg::lsec_apb_req_s apbReq,
  output lsec_pkg::lsec_apb_rsp_s     apbRsp,
  output lsec_pkg::lsec_drive_s       drive
);
  localparam int unsigned CW = lsec_pkg::CNT_W;

  typedef struct packed {
    lsec_pkg::lsec_state_e           st;
    logic                            enPrev;
    logic [CW-1:0]                   lowCnt;
    logic [CW-1:0]                   highCnt;
    logic [CW-1:0]                   burstCnt;
    logic [lsec_pkg::STEP_W-1:0]     step;
    logic [lsec_pkg::STAGE_W-1:0]    stage;
    logic                            timedOut;
    logic                            hot;
    logic                            allow;
    lsec_pkg::lsec_drive_s           drv;
    logic [31:0]                     rdata;
    logic                            slverr;
  } lsec_ctrl_s;

  lsec_ctrl_s q;
  lsec_ctrl_s n;
  logic       enClean;
  logic       rampTick;

  function automatic lsec_pkg::lsec_reg_e regOf(input logic [lsec_pkg::ADDR_W-1:0] a);
    if (a == lsec_pkg::CTRL_OFS) begin
      regOf = lsec_pkg::LSEC_REG_CTRL;
    end else if (a == lsec_pkg::STATUS_OFS) begin
      regOf = lsec_pkg::LSEC_REG_STATUS;
    end else if (a == lsec_pkg::LEVEL_OFS) begin
      regOf = lsec_pkg::LSEC_REG_LEVEL;
    end else begin
      regOf = lsec_pkg::LSEC_REG_NONE;
    end
  endfunction

  lsec_deglitch #(
    .HOLD_CYC (lsec_pkg::GLITCH_CYC)
  ) u_deglitch (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rawIn    (pins.enable),
    .cleanOut (enClean)
  );

  lsec_tick_div #(
    .DIV (RAMP_CYC)
  ) u_ramp_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (q.st == lsec_pkg::LSEC_RAMP),
    .tick    (rampTick)
  );

  always_comb begin
    logic                         rise;
    logic                         shutNow;
    logic                         armed;
    logic                         active;
    logic                         blocked;
    logic                         shortAct;
    logic [lsec_pkg::STAGE_W-1:0] stageEff;
    logic [31:0]                  statusWord;
    logic [31:0]                  levelWord;
    lsec_pkg::lsec_reg_e          sel;
    rise       = 1'b0;
    shutNow    = 1'b0;
    armed      = 1'b0;
    active     = 1'b0;
    blocked    = 1'b0;
    shortAct   = 1'b0;
    stageEff   = '0;
    statusWord = '0;
    levelWord  = '0;
    sel        = lsec_pkg::LSEC_REG_NONE;
    n = q;

    // edges are taken only from the filtered enable
    rise     = enClean & ~q.enPrev; // R3
    n.enPrev = enClean;

    // low time counted only while up; strictly longer than the delay shuts down
    if (enClean) begin
      n.lowCnt = '0;
    end else if (q.st != lsec_pkg::LSEC_SHUT) begin
      if (q.lowCnt == CW'(SHDN_CYC)) begin
        shutNow = 1'b1; // R2
      end else begin
        n.lowCnt = q.lowCnt + 1'b1;
      end
    end

    if (rise) begin
      n.step = (q.step == lsec_pkg::STEP_MAX) ? 7'h01 : q.step + 7'h01; // R16
    end

    case (q.st)
      lsec_pkg::LSEC_SHUT: begin
        if (rise) begin
          n.st      = lsec_pkg::LSEC_WAIT;
          n.highCnt = '0;
        end
      end
      lsec_pkg::LSEC_WAIT: begin
        // dimming pulses keep resetting the wait; only a steady high starts the ramp
        if (!enClean) begin
          n.highCnt = '0;
        end else if (q.highCnt == CW'(TURN_ON_CYC - 1)) begin
          n.st    = lsec_pkg::LSEC_RAMP; // R5
          n.stage = '0;
        end else begin
          n.highCnt = q.highCnt + 1'b1;
        end
      end
      lsec_pkg::LSEC_RAMP: begin
        if (q.stage == lsec_pkg::STAGE_FULL) begin
          n.st = lsec_pkg::LSEC_ON;
        end else if (rampTick) begin
          n.stage = q.stage + 4'h1; // R4
        end
      end
      lsec_pkg::LSEC_ON: begin
        // new step applies at once, the ramp is not rerun
        n.stage = lsec_pkg::STAGE_FULL; // R17
      end
      default: begin
        n.st = lsec_pkg::LSEC_SHUT;
      end
    endcase

    armed  = (q.st == lsec_pkg::LSEC_ON) ||
             ((q.st == lsec_pkg::LSEC_RAMP) && (q.stage != '0)); // R8
    active = armed; // R1

    // thermal trip latches while the part is up
    if (pins.overTemp && q.st != lsec_pkg::LSEC_SHUT) begin
      n.hot = 1'b1; // R14
    end

    // burst timer only in flash mode; torch holds it
    if (active && pins.flashSel && !q.timedOut) begin // R11
      if (q.burstCnt == CW'(TIMEOUT_CYC - 1)) begin
        n.timedOut = 1'b1; // R12
      end else begin
        n.burstCnt = q.burstCnt + 1'b1; // R20
      end
    end

    if (shutNow) begin
      n.st       = lsec_pkg::LSEC_SHUT;
      n.step     = '0; // R19
      n.stage    = '0;
      n.highCnt  = '0;
      n.lowCnt   = '0;
      n.burstCnt = '0; // R20
      n.timedOut = 1'b0; // R13
      // a part still hot re-latches on the next enable
      n.hot      = 1'b0; // R15
    end

    // step is untouched while blocked so service resumes at the same level
    blocked  = ~q.allow | pins.supplyLow | q.hot | q.timedOut; // R6 R7 R13 R14
    shortAct = armed & pins.shortDet; // R8
    stageEff = (q.st == lsec_pkg::LSEC_ON) ? lsec_pkg::STAGE_FULL : q.stage;

    n.drv.sinkOn  = active & ~blocked & ~shortAct; // R9 R10
    n.drv.senseOn = active & ~blocked & shortAct; // R9
    n.drv.step    = q.step;
    n.drv.stage   = active ? stageEff : '0;
    // widen both factors first: 64 x 8 does not fit the seven-bit step
    n.drv.level   = (active & ~blocked & ~shortAct) ?
                    ({3'h0, q.step} * {6'h0, stageEff}) : '0;

    statusWord[lsec_pkg::ST_STATE_LSB +: 2]   = q.st;
    statusWord[lsec_pkg::ST_TIMEOUT_BIT]      = q.timedOut;
    statusWord[lsec_pkg::ST_HOT_BIT]          = q.hot;
    statusWord[lsec_pkg::ST_SHORT_BIT]        = shortAct;
    statusWord[lsec_pkg::ST_SUPLOW_BIT]       = pins.supplyLow;
    statusWord[lsec_pkg::ST_FLASH_BIT]        = pins.flashSel;
    levelWord[lsec_pkg::LV_STEP_LSB +: lsec_pkg::STEP_W]   = q.step;
    levelWord[lsec_pkg::LV_STAGE_LSB +: lsec_pkg::STAGE_W] = stageEff;

    // read data and error are prepared in the setup cycle for zero wait states
    sel = regOf(apbReq.paddr);
    if (apbReq.psel && !apbReq.penable) begin
      n.slverr = (sel == lsec_pkg::LSEC_REG_NONE);
      if (apbReq.pwrite) begin
        n.rdata = '0;
      end else if (sel == lsec_pkg::LSEC_REG_CTRL) begin
        n.rdata = {31'h0, q.allow};
      end else if (sel == lsec_pkg::LSEC_REG_STATUS) begin
        n.rdata = statusWord;
      end else if (sel == lsec_pkg::LSEC_REG_LEVEL) begin
        n.rdata = levelWord;
      end else begin
        n.rdata = '0;
      end
    end
    if (apbReq.psel && apbReq.penable && apbReq.pwrite && sel == lsec_pkg::LSEC_REG_CTRL) begin
      n.allow = apbReq.pwdata[lsec_pkg::CTRL_ALLOW_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q       <= '0;
      q.allow <= lsec_pkg::CTRL_ALLOW_RST;
    end else begin
      q <= n;
    end
  end

  assign apbRsp.prdata  = q.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = q.slverr & apbReq.psel & apbReq.penable;
  assign drive          = q.drv;
endmodule

// *** logic/lsec_ctrl_dummy_never.sv ***
// no logic: the block needs only the package, control, filter and divider

// *** bench/lsec_ctrl_checker.sv ***
// assertions on the led sink control ports
`timescale 1ns/10ps
module lsec_ctrl_checker #(
  parameter int unsigned SHDN_CYC = 50
) (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire lsec_pkg::lsec_pins_s    pins,
  input wire lsec_pkg::lsec_apb_req_s apbReq,
  input wire lsec_pkg::lsec_apb_rsp_s apbRsp,
  input wire lsec_pkg::lsec_drive_s   drive
);
  int lowCnt;
  // raw low run; cleared in reset, where the step is zero and no shutdown can follow
  always_ff @(posedge clk_sys) begin
    if (rst || pins.enable) begin
      lowCnt <= 0;
    end else if (lowCnt < 1000) begin
      lowCnt <= lowCnt + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_lowHeld;
    pins.supplyLow [*3];
  endsequence
  sequence s_stepMoved;
    drive.step != $past(drive.step) && drive.step != 7'h00;
  endsequence
  a_sense_excl: assert property (drive.senseOn |-> !drive.sinkOn && drive.stage != 4'h0)
    else $error("sense current with sink on or unarmed");
  a_supply_lock: assert property (s_lowHeld |-> !drive.sinkOn)
    else $error("sink on during supply lockout");
  a_level_prod: assert property (drive.level ==
    (drive.sinkOn ? {3'h0, drive.step} * {6'h0, drive.stage} : 10'h0))
    else $error("level not step times stage");
  a_stage_step: assert property ($changed(drive.stage) |->
    drive.stage == $past(drive.stage) + 4'h1 || drive.stage == 4'h0)
    else $error("ramp stage skipped");
  // a counted edge needs four raw high samples, seen three to six edges before the step shows
  a_glitch_ign: assert property (s_stepMoved |-> $past(pins.enable, 3) && $past(pins.enable, 4)
    && $past(pins.enable, 5) && $past(pins.enable, 6))
    else $error("step moved on a short pulse");
  a_step_wrap: assert property (($past(drive.step) == lsec_pkg::STEP_MAX
    && drive.step != lsec_pkg::STEP_MAX && drive.step != 7'h00) |-> drive.step == 7'h01)
    else $error("step did not wrap to one");
  a_shdn_delay: assert property ((drive.step == 7'h00 && $past(drive.step) != 7'h00
    && !$past(rst)) |-> lowCnt >= SHDN_CYC)
    else $error("shutdown before the delay");
  a_bad_addr: assert property ((apbReq.psel && apbReq.penable
    && !(apbReq.paddr inside {8'h00, 8'h04, 8'h08})) |-> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

// *** bench/lsec_host_model.sv ***
// host gpio model driving the enable and mode pins
`timescale 1ns/10ps
module lsec_host_model (
  input  wire logic clk_sys,
  output logic      enable,
  output logic      flashSel
);
  initial begin
    enable = 1'b0;
    flashSel = 1'b0;
  end
  task automatic mode(input logic f);
    @(posedge clk_sys);
    flashSel <= f;
  endtask
  // a long low is the only way the host clears a timeout or thermal trip
  task automatic idle(input int c);
    @(posedge clk_sys);
    enable <= 1'b0;
    repeat (c) @(posedge clk_sys);
  endtask
  // caller keeps widths within 25..500 cycles; enable is left high at the end
  task automatic pulses(input int n, input int hi, input int lo);
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      enable <= 1'b0;
      repeat (lo) @(posedge clk_sys);
      enable <= 1'b1;
      repeat (hi) @(posedge clk_sys);
    end
  endtask
  task automatic glitch(input int c);
    @(posedge clk_sys);
    enable <= 1'b1;
    repeat (c) @(posedge clk_sys);
    enable <= 1'b0;
  endtask
endmodule

// *** bench/lsec_ctrl_tb.sv ***
// self-checking bench for the led sink control
`timescale 1ns/10ps
module lsec_ctrl_tb;
  logic                    clk_sys;
  logic                    rst;
  logic                    sl;
  logic                    ht;
  logic                    sh;
  wire logic               en;
  wire logic               fl;
  wire lsec_pkg::lsec_pins_s pins = {en, fl, sl, ht, sh};
  lsec_pkg::lsec_apb_req_s req;
  lsec_pkg::lsec_apb_rsp_s rsp;
  lsec_pkg::lsec_drive_s   drive;
  logic [31:0]             seed = 32'hd5b5;
  int                      failures = 0;
  int                      compares = 0;
  always #10 clk_sys = ~clk_sys;
  lsec_ctrl #(.SHDN_CYC(50), .TURN_ON_CYC(40), .TIMEOUT_CYC(300), .RAMP_CYC(5)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .pins(pins), .apbReq(req), .apbRsp(rsp), .drive(drive));
  lsec_host_model u_host (.clk_sys(clk_sys), .enable(en), .flashSel(fl));
  function automatic logic [31:0] rnd(input int m);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed % m;
  endfunction
  function automatic logic [31:0] dv(input logic on, input logic se, input int c,
                                     input logic [3:0] g);
    logic [6:0] s;
    s = 7'(((c - 1) % 64) + 1);
    return {9'h0, on, se, s, g, on ? {3'h0, s} * {6'h0, g} : 10'h0};
  endfunction
  function automatic logic [31:0] st(input logic [1:0] s, input logic to, input logic hot);
    return {25'h0, fl, sl, sh, hot, to, s};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    logic [31:0] r;
    logic        e;
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    @(posedge clk_sys);
    while (rsp.pready !== 1'b1) @(posedge clk_sys);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (!wr) chk(r, ed);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic go(input int n);
    u_host.idle(70);
    u_host.pulses(n, 25 + rnd(8), 25 + rnd(8));
    w(100);
  endtask
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    give_verdict;
  end
  initial begin
    clk_sys = 1'b0;
    rst <= 1'b1;
    sl  <= 1'b0;
    ht  <= 1'b0;
    sh  <= 1'b0;
    req <= '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b0, lsec_pkg::CTRL_OFS, 32'h0, 32'h1, 1'b0);
    acc(1'b0, lsec_pkg::STATUS_OFS, 32'h0, st(2'b00, 1'b0, 1'b0), 1'b0);
    acc(1'b1, lsec_pkg::LEVEL_OFS, rnd(32'h7fff_ffff), 32'h0, 1'b0);
    acc(1'b0, lsec_pkg::LEVEL_OFS, 32'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h0c, rnd(32'h7fff_ffff), 32'h0, 1'b1);
    acc(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    $display("test registers done");
    u_host.glitch(3);
    w(10);
    chk(32'(drive), dv(1'b0, 1'b0, 0, 4'h0));
    $display("test glitch done");
    // 63 and 64 put the extra edge on the wrap boundary
    for (int i = 0; i < 3; i++) begin
      int n;
      n = (i == 0) ? 1 + rnd(6) : 62 + i;
      go(n);
      chk(32'(drive), dv(1'b1, 1'b0, n, 4'h8));
      u_host.pulses(1, 25, 45);
      w(10);
      chk(32'(drive), dv(1'b1, 1'b0, n + 1, 4'h8));
      u_host.idle(70);
      w(2);
      chk(32'(drive), dv(1'b0, 1'b0, 0, 4'h0));
    end
    $display("test dimming done");
    @(posedge clk_sys) sh <= 1'b1;
    u_host.idle(70);
    u_host.pulses(1, 30, 30);
    w(20);
    chk(32'(drive), dv(1'b0, 1'b0, 1, 4'h0));
    w(80);
    chk(32'(drive), dv(1'b0, 1'b1, 1, 4'h8));
    @(posedge clk_sys) sh <= 1'b0;
    w(3);
    chk(32'(drive), dv(1'b1, 1'b0, 1, 4'h8));
    @(posedge clk_sys) sl <= 1'b1;
    w(4);
    chk(32'(drive), dv(1'b0, 1'b0, 1, 4'h8));
    @(posedge clk_sys) sl <= 1'b0;
    w(3);
    chk(32'(drive), dv(1'b1, 1'b0, 1, 4'h8));
    acc(1'b1, lsec_pkg::CTRL_OFS, 32'h0, 32'h0, 1'b0);
    w(3);
    chk(32'(drive), dv(1'b0, 1'b0, 1, 4'h8));
    acc(1'b1, lsec_pkg::CTRL_OFS, 32'h1, 32'h0, 1'b0);
    w(400);
    chk(32'(drive), dv(1'b1, 1'b0, 1, 4'h8));
    acc(1'b0, lsec_pkg::STATUS_OFS, 32'h0, st(2'b10, 1'b0, 1'b0), 1'b0);
    $display("test torch protection done");
    u_host.mode(1'b1);
    go(2);
    chk(32'(drive), dv(1'b1, 1'b0, 2, 4'h8));
    w(260);
    chk(32'(drive.sinkOn), 32'h0);
    acc(1'b0, lsec_pkg::STATUS_OFS, 32'h0, st(2'b10, 1'b1, 1'b0), 1'b0);
    @(posedge clk_sys) sl <= 1'b1;
    w(3);
    @(posedge clk_sys) sl <= 1'b0;
    u_host.pulses(1, 25, 25);
    w(10);
    chk(32'(drive.sinkOn), 32'h0);
    go(2);
    chk(32'(drive), dv(1'b1, 1'b0, 2, 4'h8));
    $display("test flash timeout done");
    u_host.mode(1'b0);
    @(posedge clk_sys) ht <= 1'b1;
    w(3);
    chk(32'(drive.sinkOn), 32'h0);
    acc(1'b0, lsec_pkg::STATUS_OFS, 32'h0, st(2'b10, 1'b0, 1'b1), 1'b0);
    @(posedge clk_sys) ht <= 1'b0;
    w(5);
    chk(32'(drive.sinkOn), 32'h0);
    go(1);
    chk(32'(drive), dv(1'b1, 1'b0, 1, 4'h8));
    $display("test thermal done");
    give_verdict;
  end
endmodule
bind lsec_ctrl lsec_ctrl_checker #(.SHDN_CYC(SHDN_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .pins(pins), .apbReq(apbReq), .apbRsp(apbRsp), .drive(drive));
